/* logic/msf_defs.svh */
// register indices, field positions, reset values and timing counts
`ifndef MSF_DEFS_SVH
`define MSF_DEFS_SVH
// ====================================================================
// register indices (byte address is four times the index)
`define MSF_IDX_SRDIV 8'h19
`define MSF_IDX_RFSEL 8'h1A
`define MSF_IDX_GYRO 8'h1B
`define MSF_IDX_ACC 8'h1C
`define MSF_IDX_ACC2 8'h1D
`define MSF_IDX_LP 8'h1E
`define MSF_IDX_GSTAT 8'h20
`define MSF_IDX_ASTAT 8'h21
// ====================================================================
// field positions
`define MSF_ST_X_BIT 7
`define MSF_ST_Y_BIT 6
`define MSF_ST_Z_BIT 5
`define MSF_FS_LSB 3
`define MSF_BYP_LSB 0
`define MSF_ACC_BYP_BIT 3
`define MSF_ACC_LPF_LSB 0
`define MSF_LP_EN_BIT 7
`define MSF_LP_RATE_LSB 0
`define MSF_STAT_BW_LSB 16
// ====================================================================
// reset values and writable masks
`define MSF_RST_CFG 8'h00
`define MSF_MASK_GYRO 8'hFB
`define MSF_MASK_ACC 8'hF8
`define MSF_MASK_ACC2 8'h0F
`define MSF_MASK_RFSEL 8'h07
`define MSF_MASK_LP 8'h8F
`define MSF_MASK_SRDIV 8'hFF
// ====================================================================
// timing: clock period and internal sample periods, in ns
`define MSF_CLK_NS 50
`define MSF_T32K_NS 31250
`define MSF_T8K_NS 125000
`define MSF_T4K_NS 250000
`define MSF_T1K_NS 1000000
`define MSF_LP_MAX_SEL 11
`endif

/* logic/msf_pkg.sv */
// types shared by the motion sensor filter configuration block
package msf_pkg;
	// internal sample rate of a path
	typedef enum logic [1:0] {MSF_FS_32K, MSF_FS_8K, MSF_FS_4K, MSF_FS_1K} msf_rate_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic [7:0] dec;
		logic tick;
	} msf_strobe_state_t;

	typedef struct packed {
		logic [7:0] gyroCfg;
		logic [7:0] accCfg;
		logic [7:0] accCfg2;
		logic [7:0] rfSel;
		logic [7:0] lpCfg;
		logic [7:0] srDiv;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] gyroRangeSel;
		logic [1:0] accelRangeSel;
		logic [2:0] gyroSelftest;
		logic [2:0] accelSelftest;
		logic gyroFilterOn;
		logic accelFilterOn;
		logic accelLowPower;
		logic [15:0] gyroBwHz;
		logic [15:0] accelBwHz;
	} msf_top_state_t;
endpackage

/* logic/msf_strobe.sv */
// sample strobe divider with 1+n decimation
`timescale 1ns/10ps
module msf_strobe
	import msf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [31:0] period,
	input wire logic [7:0] decim,
	output logic tick
);
	msf_strobe_state_t st, next_st;
	logic baseTick;

	// ================================================================
	// next state
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		baseTick = 1'b0;
		if (!enable) begin
			next_st.cnt = 32'h0000_0000;
			next_st.dec = 8'h00;
		end else if (st.cnt >= period - 32'h0000_0001) begin
			// >= so a shortened period never strands the counter
			next_st.cnt = 32'h0000_0000;
			baseTick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 32'h0000_0001;
		end
		// keep one base tick out of every 1+decim
		if (baseTick) begin
			if (st.dec >= decim) begin
				next_st.dec = 8'h00;
				next_st.tick = 1'b1;
			end else begin
				next_st.dec = st.dec + 8'h01;
			end
		end
	end

	// ================================================================
	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule

/* logic/msf_top.sv */
// gyro, temperature and accel range and filter configuration with APB access
//
// Function
// - gyro/temp filtered only when bypass field is 00
// - stored bypass field is inverse of filter select
// - gyro rate 32k, or 8k/1k by setting
// - gyro bandwidth from select and filter setting
// - gyro range code picks 250 to 2000 dps
// - accel range code picks 2g to 16g
// - accel bypass bit 3 is inverted select
// - accel lpf setting bits 2:0 when selected
// - accel normal rate 4k or 1k, bandwidths
// - output rate divided by one plus divider
// - low power duty-cycles accel, select forced 0
// - low power rates give 1.1 kHz bandwidth
// - divider only for gyro select 11, setting 1..6, or accel select 1
`timescale 1ns/10ps
`include "msf_defs.svh"
module msf_top
	import msf_pkg::*;
#(
	parameter int unsigned CYC_32K = `MSF_T32K_NS / `MSF_CLK_NS,
	parameter int unsigned CYC_8K = `MSF_T8K_NS / `MSF_CLK_NS,
	parameter int unsigned CYC_4K = `MSF_T4K_NS / `MSF_CLK_NS,
	parameter int unsigned CYC_1K = `MSF_T1K_NS / `MSF_CLK_NS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [1:0] gyroRangeSel,
	output logic [1:0] accelRangeSel,
	output logic [2:0] gyroSelftest,
	output logic [2:0] accelSelftest,
	output logic gyroFilterOn,
	output logic accelFilterOn,
	output logic accelLowPower,
	output logic [15:0] gyroBwHz,
	output logic [15:0] accelBwHz,
	output logic gyroSampleTick,
	output logic accelSampleTick
);
	msf_top_state_t st, next_st;
	// settings decode
	logic [1:0] gyroSelNow;
	logic [2:0] rateSelNow;
	logic accSelNow;
	logic lpNow;
	logic [3:0] lpRateNow;
	msf_rate_t gyroRate;
	msf_rate_t accelRate;
	logic gyroDivOk;
	// strobe control
	logic [31:0] gyroPeriod;
	logic [31:0] accelPeriod;
	logic [7:0] gyroDecim;
	logic [7:0] accelDecim;
	// bus decode
	logic [7:0] wIdx;
	logic addrOk;
	logic wrHit;
	logic rdHit;
	logic [7:0] wrByte;
	logic gyroRestart;
	logic accelRestart;
	logic setup;
	logic access;
	logic [31:0] rdVal;

	// ================================================================
	// field decode helpers

	// self-test enables sit in bits 7:5 as X, Y, Z in both range words
	function automatic logic [2:0] selftestOf(input logic [7:0] cfg);
		selftestOf = {cfg[`MSF_ST_X_BIT], cfg[`MSF_ST_Y_BIT], cfg[`MSF_ST_Z_BIT]};
	endfunction

	// full-scale code shares bits 4:3 in both range words
	function automatic logic [1:0] rangeOf(input logic [7:0] cfg);
		rangeOf = cfg[`MSF_FS_LSB +: 2];
	endfunction

	// reserved low-power codes run at the fastest rate rather than stopping
	function automatic logic [3:0] lpCodeOf(input logic [7:0] cfg);
		if (cfg[`MSF_LP_RATE_LSB +: 4] > 4'(`MSF_LP_MAX_SEL)) begin
			lpCodeOf = 4'(`MSF_LP_MAX_SEL);
		end else begin
			lpCodeOf = cfg[`MSF_LP_RATE_LSB +: 4];
		end
	endfunction

	// logical select is the stored bypass field inverted
	function automatic logic [1:0] gyroSelect(input logic [7:0] cfg);
		gyroSelect = ~cfg[`MSF_BYP_LSB +: 2];
	endfunction

	// ================================================================
	// rate and bandwidth tables

	// the 1 kHz rate belongs to the averaging settings 1..6 only
	function automatic msf_rate_t gyroRateOf(input logic [1:0] fsel, input logic [2:0] rsel);
		if (fsel != 2'b11) begin
			gyroRateOf = MSF_FS_32K;
		end else if (rsel == 3'h0 || rsel == 3'h7) begin
			gyroRateOf = MSF_FS_8K;
		end else begin
			gyroRateOf = MSF_FS_1K;
		end
	endfunction

	// bandwidth in Hz, kept as a plain binary count
	function automatic logic [15:0] gyroBwOf(input logic [1:0] fsel, input logic [2:0] rsel);
		if (!fsel[0]) begin
			gyroBwOf = 16'h2260; // 8800 Hz
		end else if (!fsel[1]) begin
			gyroBwOf = 16'h0E10; // 3600 Hz
		end else begin
			unique case (rsel)
				3'h0: gyroBwOf = 16'h00FA; // 250
				3'h1: gyroBwOf = 16'h00B8; // 184
				3'h2: gyroBwOf = 16'h005C; // 92
				3'h3: gyroBwOf = 16'h0029; // 41
				3'h4: gyroBwOf = 16'h0014; // 20
				3'h5: gyroBwOf = 16'h000A; // 10
				3'h6: gyroBwOf = 16'h0005; // 5
				3'h7: gyroBwOf = 16'h0E10; // 3600
			endcase
		end
	endfunction

	// low power outranks the filter select for the reported bandwidth
	function automatic logic [15:0] accelBwOf(input logic lp, input logic sel,
			input logic [2:0] lpf);
		if (lp) begin
			accelBwOf = 16'h044C; // 1100 Hz in every low-power rate
		end else if (!sel) begin
			accelBwOf = 16'h046A; // 1130 Hz
		end else begin
			unique case (lpf)
				3'h0: accelBwOf = 16'h01CC; // 460
				3'h1: accelBwOf = 16'h00B8; // 184
				3'h2: accelBwOf = 16'h005C; // 92
				3'h3: accelBwOf = 16'h0029; // 41
				3'h4: accelBwOf = 16'h0014; // 20
				3'h5: accelBwOf = 16'h000A; // 10
				3'h6: accelBwOf = 16'h0005; // 5
				3'h7: accelBwOf = 16'h01CC; // 460
			endcase
		end
	endfunction

	// low power counts from the 1 kHz base; its rate code sets the duty cycle
	function automatic msf_rate_t accelRateOf(input logic lp, input logic sel);
		if (lp || sel) begin
			accelRateOf = MSF_FS_1K;
		end else begin
			accelRateOf = MSF_FS_4K;
		end
	endfunction

	// clock cycles per internal sample at each rate
	function automatic logic [31:0] periodOf(input msf_rate_t r);
		unique case (r)
			MSF_FS_32K: periodOf = 32'(CYC_32K);
			MSF_FS_8K: periodOf = 32'(CYC_8K);
			MSF_FS_4K: periodOf = 32'(CYC_4K);
			MSF_FS_1K: periodOf = 32'(CYC_1K);
		endcase
	endfunction

	// ================================================================
	// bus helpers

	// only the six settings words and the two status words answer cleanly
	function automatic logic idxMapped(input logic [7:0] idx);
		unique case (idx)
			`MSF_IDX_SRDIV, `MSF_IDX_RFSEL, `MSF_IDX_GYRO: idxMapped = 1'b1;
			`MSF_IDX_ACC, `MSF_IDX_ACC2, `MSF_IDX_LP: idxMapped = 1'b1;
			`MSF_IDX_GSTAT, `MSF_IDX_ASTAT: idxMapped = 1'b1;
			default: idxMapped = 1'b0;
		endcase
	endfunction

	// writable bits per settings word; reserved bits never reach the store
	function automatic logic [7:0] maskOf(input logic [7:0] idx);
		unique case (idx)
			`MSF_IDX_SRDIV: maskOf = `MSF_MASK_SRDIV;
			`MSF_IDX_RFSEL: maskOf = `MSF_MASK_RFSEL;
			`MSF_IDX_GYRO: maskOf = `MSF_MASK_GYRO;
			`MSF_IDX_ACC: maskOf = `MSF_MASK_ACC;
			`MSF_IDX_ACC2: maskOf = `MSF_MASK_ACC2;
			`MSF_IDX_LP: maskOf = `MSF_MASK_LP;
			default: maskOf = 8'h00;
		endcase
	endfunction

	// ================================================================
	// live settings, taken from the stored registers
	always_comb begin
		gyroSelNow = gyroSelect(st.gyroCfg);
		rateSelNow = st.rfSel[2:0];
		lpNow = st.lpCfg[`MSF_LP_EN_BIT];
		lpRateNow = lpCodeOf(st.lpCfg);
		// low power forces the unfiltered accel path
		accSelNow = lpNow ? 1'b0 : ~st.accCfg2[`MSF_ACC_BYP_BIT];
		gyroRate = gyroRateOf(gyroSelNow, rateSelNow);
		accelRate = accelRateOf(lpNow, accSelNow);
		gyroDivOk = (gyroSelNow == 2'b11) && (rateSelNow != 3'h0)
			&& (rateSelNow != 3'h7);
	end

	// ================================================================
	// strobe periods and decimation
	always_comb begin
		gyroPeriod = periodOf(gyroRate);
		gyroDecim = gyroDivOk ? st.srDiv : 8'h00;
		if (lpNow) begin
			// low-power rates halve per code step down from 1 kHz
			accelPeriod = 32'(CYC_1K) << (4'(`MSF_LP_MAX_SEL) - lpRateNow);
			accelDecim = 8'h00;
		end else begin
			accelPeriod = periodOf(accelRate);
			// accel divider only on the 1 kHz filtered path
			accelDecim = accSelNow ? st.srDiv : 8'h00;
		end
	end

	// ================================================================
	// APB decode
	always_comb begin
		setup = psel && !penable;
		access = psel && penable;
		wIdx = paddr[9:2];
		addrOk = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00)
			&& idxMapped(wIdx);
		// read data launches from setup so it stands in the access cycle
		rdHit = setup && !pwrite && addrOk;
		// a write lands only in the access cycle that ready answers
		wrHit = access && st.pready && pwrite && addrOk && pstrb[0];
		wrByte = pwdata[7:0] & maskOf(wIdx);
		// a rate write parks its strobe for a cycle so the next interval is whole
		gyroRestart = wrHit && (wIdx == `MSF_IDX_GYRO || wIdx == `MSF_IDX_RFSEL
			|| wIdx == `MSF_IDX_SRDIV);
		accelRestart = wrHit && (wIdx == `MSF_IDX_ACC2 || wIdx == `MSF_IDX_LP
			|| wIdx == `MSF_IDX_SRDIV);
		rdVal = 32'h0000_0000;
		// reserved bits are never stored, so they read as zero
		unique case (wIdx)
			`MSF_IDX_SRDIV: rdVal[7:0] = st.srDiv;
			`MSF_IDX_RFSEL: rdVal[7:0] = st.rfSel;
			`MSF_IDX_GYRO: rdVal[7:0] = st.gyroCfg;
			`MSF_IDX_ACC: rdVal[7:0] = st.accCfg;
			`MSF_IDX_ACC2: rdVal[7:0] = st.accCfg2;
			`MSF_IDX_LP: rdVal[7:0] = st.lpCfg;
			`MSF_IDX_GSTAT: begin
				rdVal[`MSF_STAT_BW_LSB +: 16] = st.gyroBwHz;
				rdVal[1:0] = gyroRate;
				rdVal[2] = st.gyroFilterOn;
				rdVal[3] = gyroDivOk;
			end
			`MSF_IDX_ASTAT: begin
				rdVal[`MSF_STAT_BW_LSB +: 16] = st.accelBwHz;
				rdVal[1:0] = lpNow ? MSF_FS_1K : accelRate;
				rdVal[2] = st.accelFilterOn;
				rdVal[3] = st.accelLowPower;
			end
			default: rdVal = 32'h0000_0000;
		endcase
	end

	// ================================================================
	// next state: bus answer, register writes, decoded outputs
	always_comb begin
		next_st = st;
		// zero wait states: ready is raised for the access cycle only
		next_st.pready = setup;
		next_st.pslverr = setup && !addrOk;
		next_st.prdata = rdHit ? rdVal : 32'h0000_0000;
		// a write lands at the access edge, low byte lane only
		if (wrHit) begin
			unique case (wIdx)
				`MSF_IDX_SRDIV: next_st.srDiv = wrByte;
				`MSF_IDX_RFSEL: next_st.rfSel = wrByte;
				`MSF_IDX_GYRO: next_st.gyroCfg = wrByte;
				`MSF_IDX_ACC: next_st.accCfg = wrByte;
				`MSF_IDX_ACC2: next_st.accCfg2 = wrByte;
				`MSF_IDX_LP: next_st.lpCfg = wrByte;
				default: next_st.srDiv = st.srDiv;
			endcase
		end
		// outputs follow the stored settings one cycle later
		next_st.gyroRangeSel = rangeOf(st.gyroCfg);
		next_st.accelRangeSel = rangeOf(st.accCfg);
		next_st.gyroSelftest = selftestOf(st.gyroCfg);
		next_st.accelSelftest = selftestOf(st.accCfg);
		next_st.gyroFilterOn = (st.gyroCfg[`MSF_BYP_LSB +: 2] == 2'b00);
		next_st.accelFilterOn = accSelNow;
		next_st.accelLowPower = lpNow;
		next_st.gyroBwHz = gyroBwOf(gyroSelNow, rateSelNow);
		next_st.accelBwHz = accelBwOf(lpNow, accSelNow,
			st.accCfg2[`MSF_ACC_LPF_LSB +: 3]);
	end

	// ================================================================
	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ================================================================
	// sample strobes; a rate write holds the counter at zero for one
	// cycle, so the first interval at the new setting is a whole one
	msf_strobe u_gyro_strobe (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(!gyroRestart),
		.period(gyroPeriod),
		.decim(gyroDecim),
		.tick(gyroSampleTick)
	);

	msf_strobe u_accel_strobe (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(!accelRestart),
		.period(accelPeriod),
		.decim(accelDecim),
		.tick(accelSampleTick)
	);

	// ================================================================
	// outputs straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign gyroRangeSel = st.gyroRangeSel;
	assign accelRangeSel = st.accelRangeSel;
	assign gyroSelftest = st.gyroSelftest;
	assign accelSelftest = st.accelSelftest;
	assign gyroFilterOn = st.gyroFilterOn;
	assign accelFilterOn = st.accelFilterOn;
	assign accelLowPower = st.accelLowPower;
	assign gyroBwHz = st.gyroBwHz;
	assign accelBwHz = st.accelBwHz;
endmodule

/* testbench/msf_top_props.sv */
// concurrent checks on the configuration block ports
`timescale 1ns/10ps
module msf_top_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic gyroFilterOn,
	input wire logic accelFilterOn,
	input wire logic accelLowPower,
	input wire logic [15:0] gyroBwHz,
	input wire logic [15:0] accelBwHz,
	input wire logic gyroSampleTick,
	input wire logic accelSampleTick
);
	// ====
	// bus handshake
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_ready_slot: assert property (s_setup |=> s_access) else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data leak");
	// ====
	// decoded settings; $past(rst_n) skips the first edge after release
	a_gyro_bypass: assert property ($past(rst_n) && !gyroFilterOn |->
		gyroBwHz inside {16'h2260, 16'h0E10}) else $error("gyro bypass bw");
	a_acc_bypass: assert property ($past(rst_n) && !accelFilterOn && !accelLowPower |->
		accelBwHz == 16'h046A) else $error("accel bypass bw");
	a_lp_force: assert property ($past(rst_n) && accelLowPower |->
		!accelFilterOn && accelBwHz == 16'h044C) else $error("low power select");
	// shortest period is five cycles, so four quiet cycles follow a tick
	a_gtick_pulse: assert property (gyroSampleTick |=> !gyroSampleTick [*4])
		else $error("gyro tick width");
	a_atick_pulse: assert property (accelSampleTick |=> !accelSampleTick [*4])
		else $error("accel tick width");
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the filter and range configuration block
`timescale 1ns/10ps
`include "msf_defs.svh"
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, gyroFilterOn, accelFilterOn, accelLowPower;
	logic gyroSampleTick, accelSampleTick;
	logic [1:0] gyroRangeSel, accelRangeSel;
	logic [2:0] gyroSelftest, accelSelftest;
	logic [15:0] gyroBwHz, accelBwHz, x;
	int badCount = 0;
	int nCompared = 0;
	int cyc = 0;
	int n;
	logic [15:0] gt[8] = '{16'h00FA, 16'h00B8, 16'h005C, 16'h0029, 16'h0014, 16'h000A,
		16'h0005, 16'h0E10};
	logic [15:0] at[8] = '{16'h01CC, 16'h00B8, 16'h005C, 16'h0029, 16'h0014, 16'h000A,
		16'h0005, 16'h01CC};
	// short periods keep tick measurements quick
	msf_top #(.CYC_32K(5), .CYC_8K(10), .CYC_4K(20), .CYC_1K(40)) u_dut (.core_clk, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.gyroRangeSel, .accelRangeSel, .gyroSelftest, .accelSelftest, .gyroFilterOn,
		.accelFilterOn, .accelLowPower, .gyroBwHz, .accelBwHz, .gyroSampleTick,
		.accelSampleTick);
	// 50 ns period
	always #25 core_clk = ~core_clk;
	// ====
	// helpers
	function logic [11:0] ad(logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task chk(string s, logic [31:0] xp, logic [31:0] g);
		nCompared++;
		if (g !== xp) begin
			badCount++;
			$display("mismatch %s expected %0h seen %0h", s, xp, g);
		end
	endtask
	// one transfer; results are taken at the edge where ready is seen
	task apb(logic w, logic [11:0] a, logic [7:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= 4'hF;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("access cycles", 1, k);
	endtask
	// decoded outputs lag the write by one edge
	task settle;
		repeat (2) @(posedge core_clk);
	endtask
	// interval between ticks, taken after the new setting has wrapped in
	task meas(logic acc);
		for (int j = 0; j < 3; j++) begin
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while ((acc ? accelSampleTick : gyroSampleTick) !== 1'b1 && n < 1000);
		end
	endtask
	// ====
	// scenarios
	task t_reset;
		for (logic [7:0] i = `MSF_IDX_GYRO; i <= `MSF_IDX_ACC2; i++) begin
			apb(1'b0, ad(i), 8'h00);
			chk("reset value", 32'h0, r);
		end
		chk("gyro bw", 16'h00FA, gyroBwHz);
		chk("accel bw", 16'h01CC, accelBwHz);
		chk("gyro filter", 1, gyroFilterOn);
		chk("accel filter", 1, accelFilterOn);
	endtask
	task t_ranges;
		apb(1'b1, ad(`MSF_IDX_GYRO), 8'hFF);
		apb(1'b0, ad(`MSF_IDX_GYRO), 8'h00);
		chk("gyro readback", 32'hFB, r);
		apb(1'b1, ad(`MSF_IDX_ACC), 8'hFF);
		apb(1'b0, ad(`MSF_IDX_ACC), 8'h00);
		chk("accel readback", 32'hF8, r);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ad(`MSF_IDX_GYRO), {3'b101, i[1:0], 3'b000});
			apb(1'b1, ad(`MSF_IDX_ACC), {3'b010, i[1:0], 3'b000});
			settle;
			chk("gyro range", i, gyroRangeSel);
			chk("accel range", i, accelRangeSel);
			chk("gyro selftest", 3'b101, gyroSelftest);
			chk("accel selftest", 3'b010, accelSelftest);
		end
	endtask
	// stored bypass field is the inverse of the select
	task t_gbw;
		for (int b = 0; b < 4; b++) begin
			for (int s = 0; s < 8; s++) begin
				apb(1'b1, ad(`MSF_IDX_RFSEL), s[7:0]);
				apb(1'b1, ad(`MSF_IDX_GYRO), b[7:0]);
				settle;
				x = b[0] ? 16'h2260 : (b == 2) ? 16'h0E10 : gt[s];
				chk("gyro bw", x, gyroBwHz);
				chk("gyro filter", b == 0, gyroFilterOn);
			end
		end
	endtask
	task t_abw;
		for (int b = 0; b < 2; b++) begin
			for (int s = 0; s < 8; s++) begin
				apb(1'b1, ad(`MSF_IDX_ACC2), {4'h0, b[0], s[2:0]});
				settle;
				chk("accel bw", b ? 16'h046A : at[s], accelBwHz);
				chk("accel filter", b == 0, accelFilterOn);
			end
		end
		apb(1'b1, ad(`MSF_IDX_ACC2), 8'hFF);
		apb(1'b0, ad(`MSF_IDX_ACC2), 8'h00);
		chk("accel2 readback", 32'h0F, r);
	endtask
	task t_lp;
		apb(1'b1, ad(`MSF_IDX_ACC2), 8'h00);
		apb(1'b1, ad(`MSF_IDX_LP), 8'h83);
		settle;
		chk("low power", 1, accelLowPower);
		chk("lp filter", 0, accelFilterOn);
		chk("lp bw", 16'h044C, accelBwHz);
		apb(1'b1, ad(`MSF_IDX_LP), 8'h00);
		settle;
		chk("normal filter", 1, accelFilterOn);
		apb(1'b0, ad(8'h1F), 8'h00);
		chk("unmapped error", 1, e);
		chk("unmapped data", 32'h0, r);
	endtask
	// divider only stretches the 1 kHz paths
	task t_div;
		apb(1'b1, ad(`MSF_IDX_GYRO), 8'h00);
		apb(1'b1, ad(`MSF_IDX_RFSEL), 8'h01);
		apb(1'b1, ad(`MSF_IDX_SRDIV), 8'h02);
		meas(1'b0);
		chk("gyro 1k div", 120, n);
		meas(1'b1);
		chk("accel 1k div", 120, n);
		apb(1'b1, ad(`MSF_IDX_RFSEL), 8'h00);
		meas(1'b0);
		chk("gyro 8k", 10, n);
		apb(1'b1, ad(`MSF_IDX_GYRO), 8'h01);
		meas(1'b0);
		chk("gyro 32k", 5, n);
		apb(1'b1, ad(`MSF_IDX_ACC2), 8'h08);
		meas(1'b1);
		chk("accel 4k", 20, n);
		apb(1'b0, ad(`MSF_IDX_GSTAT), 8'h00);
		chk("gyro status", 32'h2260_0000, r);
		apb(1'b0, ad(`MSF_IDX_ASTAT), 8'h00);
		chk("accel status", 32'h046A_0002, r);
		apb(1'b1, ad(`MSF_IDX_LP), 8'h8A);
		meas(1'b1);
		chk("lp period", 80, n);
	endtask
	task endOfTest;
		$display("compared %0d mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset;
		t_ranges;
		t_gbw;
		t_abw;
		t_lp;
		t_div;
		endOfTest;
	end
	// hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			badCount++;
			endOfTest;
		end
	end
endmodule
bind msf_top msf_top_props u_props (.core_clk, .rst_n, .psel, .penable, .prdata, .pready,
	.pslverr, .gyroFilterOn, .accelFilterOn, .accelLowPower, .gyroBwHz, .accelBwHz,
	.gyroSampleTick, .accelSampleTick);
